// [dv/dsipr_chan_model.sv]
// serial-side model: receivers hand in characters, transmitters take them
`timescale 1ns/1ps
module dsipr_chan_model (
    input wire logic i_sys_clk,
    input wire logic i_slow,
    input wire logic [1:0] i_send,
    input wire dsipr_pkg::dsipr_byte_t i_char,
    input wire dsipr_pkg::dsipr_rx_err_t i_err,
    input wire logic [1:0] i_tx_valid,
    output logic [1:0] o_rx_push,
    output dsipr_pkg::dsipr_byte_t o_char_a,
    output dsipr_pkg::dsipr_byte_t o_char_b,
    output dsipr_pkg::dsipr_rx_err_t o_err_a,
    output dsipr_pkg::dsipr_rx_err_t o_err_b,
    output logic [1:0] o_tx_taken,
    output logic [1:0] o_tx_idle
);
    import dsipr_pkg::*;
    logic [3:0] cnt [2] = '{4'h0, 4'h0};
    initial {o_rx_push, o_tx_taken, o_char_a, o_char_b, o_err_a, o_err_b} = 26'h0;
    // lines scramble between pushes so a stale character never looks valid
    always @(posedge i_sys_clk) begin
        o_rx_push <= i_send;
        o_char_a <= i_send[0] ? i_char : ~o_char_a;
        o_char_b <= i_send[1] ? i_char : ~o_char_b;
        o_err_a <= i_send[0] ? i_err : ~o_err_a;
        o_err_b <= i_send[1] ? i_err : ~o_err_b;
        for (int c = 0; c < 2; c++) begin
            o_tx_taken[c] <= cnt[c] == 4'h1;
            if (cnt[c] != 4'h0) cnt[c] <= cnt[c] - 4'h1;
            else if (i_tx_valid[c] && !o_tx_taken[c]) cnt[c] <= i_slow ? 4'h8 : 4'h1;
        end
    end
    assign o_tx_idle = {cnt[1] == 4'h0, cnt[0] == 4'h0};
endmodule

// [dv/dsipr_regs_assertions.sv]
// port-level checks of the status/port register bank
`timescale 1ns/1ps
module dsipr_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [6:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] o_tx_valid,
    input wire dsipr_pkg::dsipr_byte_t o_interrupt_vector,
    input wire logic o_baud_rate_set_sel,
    input wire logic [15:0] o_ct_preset
);
    import dsipr_pkg::*;
    logic wd, w_iv, w_lo, w_tx;
    logic [4:0] ix;
    assign ix = i_avs_address[6:2];
    assign wd = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    assign w_iv = wd && ix == 5'h10;
    assign w_lo = wd && ix == 5'h0F;
    assign w_tx = wd && ix == 5'h03;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    sequence s_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_ans;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    property p_wait_one;
        s_req |=> s_ans;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
    property p_rd_hi;
        !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read data high bits set");
    property p_iv_val;
        w_iv |=> o_interrupt_vector == $past(i_avs_writedata[7:0]);
    endproperty
    a_iv_val: assert property (p_iv_val) else $error("vector not loaded");
    property p_iv_src;
        $changed(o_interrupt_vector) |-> $past(w_iv) || $past(w_iv, 2);
    endproperty
    a_iv_src: assert property (p_iv_src) else $error("vector changed unasked");
    property p_hi_val;
        wd && ix == 5'h0E |=> o_ct_preset[15:8] == $past(i_avs_writedata[7:0]);
    endproperty
    a_hi_val: assert property (p_hi_val) else $error("preset high not loaded");
    property p_lo_src;
        $changed(o_ct_preset[7:0]) |-> $past(w_lo) || $past(w_lo, 2);
    endproperty
    a_lo_src: assert property (p_lo_src) else $error("preset low changed unasked");
    property p_baud;
        wd && ix == 5'h0A |=> o_baud_rate_set_sel == $past(i_avs_writedata[7]);
    endproperty
    a_baud: assert property (p_baud) else $error("rate set select wrong");
    property p_tx_load;
        $rose(o_tx_valid[0]) |-> $past(w_tx) || $past(w_tx, 2);
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("holding loaded unasked");
endmodule
bind dsipr_regs dsipr_chk chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_tx_valid(o_tx_valid), .o_interrupt_vector(o_interrupt_vector), .o_baud_rate_set_sel(o_baud_rate_set_sel),
    .o_ct_preset(o_ct_preset));

// [dv/tb.sv]
// self-checking bench of the status/port register bank
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
    import dsipr_pkg::*;
    logic i_sys_clk = 1'h0, i_rst = 1'h1, i_avs_read = 1'h0, i_avs_write = 1'h0, i_ct_ready = 1'h0, i_ct_out = 1'h0;
    logic i_chan_a_transmit_clock_16x = 1'h0, slow = 1'h1, o_avs_waitrequest, o_irq_n, o_baud_rate_set_sel;
    logic [1:0] i_break_change = 2'h0, i_transmit_clock_1x = 2'h0, i_receive_clock_1x = 2'h0, send = 2'h0;
    logic [1:0] i_rx_push, i_tx_taken, i_tx_idle, o_rx_enabled, o_tx_valid;
    logic [3:0] i_avs_byteenable = 4'hF, i_general_input_pin = 4'h0;
    logic [6:0] i_avs_address = 7'h00;
    logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
    logic [2:0] o_ct_mode;
    logic [15:0] o_ct_preset;
    dsipr_byte_t i_rx_char_a, i_rx_char_b, o_tx_data_a, o_tx_data_b, o_general_output_pin, o_interrupt_vector;
    dsipr_byte_t chr = 8'h00, q, v, hi, lo;
    dsipr_rx_err_t i_rx_err_a, i_rx_err_b, err = 3'h0;
    logic [4:0] wo [4] = '{5'h08, 5'h0A, 5'h0D, 5'h1F};
    int failures = 0, compares = 0;
    always #50 i_sys_clk = ~i_sys_clk;
    dsipr_regs dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_rx_push(i_rx_push),
        .i_rx_char_a(i_rx_char_a), .i_rx_char_b(i_rx_char_b), .i_rx_err_a(i_rx_err_a), .i_rx_err_b(i_rx_err_b),
        .i_tx_taken(i_tx_taken), .i_tx_idle(i_tx_idle), .i_break_change(i_break_change), .i_ct_ready(i_ct_ready),
        .i_ct_out(i_ct_out), .i_chan_a_transmit_clock_16x(i_chan_a_transmit_clock_16x),
        .i_transmit_clock_1x(i_transmit_clock_1x), .i_receive_clock_1x(i_receive_clock_1x),
        .i_general_input_pin(i_general_input_pin), .o_rx_enabled(o_rx_enabled), .o_tx_valid(o_tx_valid),
        .o_tx_data_a(o_tx_data_a), .o_tx_data_b(o_tx_data_b), .o_general_output_pin(o_general_output_pin),
        .o_irq_n(o_irq_n), .o_interrupt_vector(o_interrupt_vector), .o_baud_rate_set_sel(o_baud_rate_set_sel),
        .o_ct_mode(o_ct_mode), .o_ct_preset(o_ct_preset));
    dsipr_chan_model chan_u (.i_sys_clk(i_sys_clk), .i_slow(slow), .i_send(send), .i_char(chr), .i_err(err),
        .i_tx_valid(o_tx_valid), .o_rx_push(i_rx_push), .o_char_a(i_rx_char_a), .o_char_b(i_rx_char_b),
        .o_err_a(i_rx_err_a), .o_err_b(i_rx_err_b), .o_tx_taken(i_tx_taken), .o_tx_idle(i_tx_idle));
    task automatic bus(input logic w, input logic [4:0] idx, input dsipr_byte_t d, output dsipr_byte_t r);
        @(posedge i_sys_clk);
        i_avs_address <= {idx, 2'h0};
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_writedata <= {24'h0, d};
        do begin
            @(posedge i_sys_clk);
        end while (o_avs_waitrequest !== 1'h0);
        r = o_avs_readdata[7:0];
        i_avs_write <= 1'h0;
        i_avs_read <= 1'h0;
    endtask
    task automatic wr(input logic [4:0] idx, input dsipr_byte_t d);
        bus(1'h1, idx, d, q);
    endtask
    task automatic rc(input logic [4:0] idx, input dsipr_byte_t e);
        bus(1'h0, idx, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic push(input dsipr_byte_t c, input dsipr_rx_err_t e);
        @(posedge i_sys_clk);
        send <= 2'h1;
        chr <= c;
        err <= e;
        @(posedge i_sys_clk);
        send <= 2'h0;
    endtask
    function automatic logic pin(input logic [1:0] s, input logic [3:0] src);
        return ~src[s];
    endfunction
    // channel A status with transmitter enabled and drained
    function automatic dsipr_byte_t stat(input logic [2:0] e, input logic ov, input logic full, input logic rdy);
        return {e, ov, 2'h3, full, rdy};
    endfunction
    task automatic report_and_stop;
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h461E));
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'h0;
        settle(1);
        `CHK(o_general_output_pin, 8'hFF)
        `CHK(o_irq_n, 1'h1)
        for (int k = 0; k < 4; k++) begin
            v = 8'($urandom);
            wr(5'h09, v);
            rc(5'h09, v);
            settle(2);
            `CHK(o_general_output_pin, ~v)
        end
        hi = 8'($urandom);
        lo = 8'($urandom);
        v = 8'($urandom);
        wr(5'h0E, hi);
        wr(5'h0F, lo);
        wr(5'h10, v);
        settle(2);
        `CHK(o_ct_preset, {hi, lo})
        rc(5'h0E, hi);
        rc(5'h10, v);
        foreach (wo[k]) rc(wo[k], 8'h00);
        @(posedge i_sys_clk);
        i_avs_byteenable <= 4'h0;
        wr(5'h10, ~v);
        i_avs_byteenable <= 4'hF;
        settle(2);
        `CHK(o_interrupt_vector, v)
        for (int b = 1; b >= 0; b--) begin
            wr(5'h0A, {b[0], 7'h50});
            settle(2);
            `CHK(o_baud_rate_set_sel, b[0])
            `CHK(o_ct_mode, 3'h5)
        end
        wr(5'h09, 8'h00);
        for (int c = 0; c < 4; c++) begin
            @(posedge i_sys_clk);
            {i_ct_out, i_transmit_clock_1x, i_receive_clock_1x, i_chan_a_transmit_clock_16x} <= 6'($urandom);
            wr(5'h08, {4'h0, c[1:0], c[1:0]});
            settle(2);
            `CHK(o_general_output_pin[3], pin(c[1:0], {i_receive_clock_1x[1], i_transmit_clock_1x[1], i_ct_out, 1'h0}))
            `CHK(o_general_output_pin[2], pin(c[1:0], {i_receive_clock_1x[0], i_transmit_clock_1x[0], i_chan_a_transmit_clock_16x, 1'h0}))
        end
        wr(5'h08, 8'hF0);
        wr(5'h03, 8'h55);
        wr(5'h07, 8'h55);
        settle(2);
        `CHK({o_tx_valid, o_tx_data_b}, 10'h000)
        wr(5'h02, 8'h04);
        wr(5'h03, v);
        settle(1);
        `CHK({o_tx_valid[0], o_tx_data_a}, {1'h1, v})
        settle(12);
        `CHK(o_general_output_pin[7:4], 4'hB)
        slow <= 1'h0;
        wr(5'h03, ~v);
        settle(4);
        `CHK(o_tx_valid[0], 1'h0)
        wr(5'h02, 8'h01);
        push(v, 3'h5);
        settle(2);
        `CHK(o_general_output_pin[4], 1'h0)
        `CHK(o_rx_enabled, 2'h1)
        rc(5'h01, stat(3'h5, 1'h0, 1'h0, 1'h1));
        rc(5'h03, v);
        rc(5'h01, stat(3'h0, 1'h0, 1'h0, 1'h0));
        wr(5'h00, 8'h01);
        push(v, 3'h2);
        push(~v, 3'h0);
        rc(5'h03, v);
        rc(5'h03, ~v);
        rc(5'h01, stat(3'h7, 1'h0, 1'h0, 1'h0));
        wr(5'h02, 8'h40);
        rc(5'h01, stat(3'h0, 1'h0, 1'h0, 1'h0));
        push(8'($urandom), 3'h7);
        repeat (4) push(8'($urandom), 3'h0);
        rc(5'h01, stat(3'h7, 1'h1, 1'h1, 1'h1));
        wr(5'h02, 8'h40);
        rc(5'h01, stat(3'h0, 1'h0, 1'h1, 1'h1));
        wr(5'h00, 8'h00);
        rc(5'h01, stat(3'h0, 1'h0, 1'h1, 1'h1));
        wr(5'h02, 8'h20);
        rc(5'h01, stat(3'h0, 1'h0, 1'h0, 1'h0));
        `CHK(o_rx_enabled, 2'h0)
        @(posedge i_sys_clk);
        i_break_change <= 2'h2;
        @(posedge i_sys_clk);
        i_break_change <= 2'h0;
        rc(5'h0C, 8'h41);
        `CHK(o_irq_n, 1'h1)
        wr(5'h0D, 8'h40);
        settle(2);
        `CHK(o_irq_n, 1'h0)
        wr(5'h06, 8'h50);
        settle(2);
        `CHK(o_irq_n, 1'h1)
        @(posedge i_sys_clk);
        i_ct_ready <= 1'h1;
        rc(5'h0C, 8'h09);
        wr(5'h0A, 8'h01);
        wr(5'h0D, 8'h80);
        i_general_input_pin <= 4'h1;
        settle(6);
        `CHK(o_irq_n, 1'h0)
        rc(5'h0B, 8'h11);
        rc(5'h0B, 8'h01);
        settle(2);
        `CHK(o_irq_n, 1'h1)
        @(posedge i_sys_clk);
        i_general_input_pin <= 4'h3;
        settle(6);
        `CHK(o_irq_n, 1'h1)
        rc(5'h0B, 8'h23);
        report_and_stop;
    end
    // tests need well under a thousand bus cycles; this margin only catches a hang
    initial begin
        #2000000;
        failures++;
        report_and_stop;
    end
endmodule

// [hdl/dsipr_defs.svh]
// register indices, field positions, command codes and reset values of the status/port register bank
`ifndef DSIPR_DEFS_SVH
`define DSIPR_DEFS_SVH

// word indices; byte address is four times the index
`define DSIPR_IDX_CHAN_MODE 5'h00
`define DSIPR_IDX_CHAN_STATUS 5'h01
`define DSIPR_IDX_CHAN_CMD 5'h02
`define DSIPR_IDX_CHAN_DATA 5'h03
`define DSIPR_CHAN_STRIDE 5'h04
`define DSIPR_IDX_OUTPUT_PIN_FUNCTION_CONFIG 5'h08
`define DSIPR_IDX_OPR 5'h09
`define DSIPR_IDX_ACR 5'h0A
`define DSIPR_IDX_INPUT_CHANGE_STATUS 5'h0B
`define DSIPR_IDX_ISR 5'h0C
`define DSIPR_IDX_IMR 5'h0D
`define DSIPR_IDX_COUNTER_PRESET_HIGH 5'h0E
`define DSIPR_IDX_COUNTER_PRESET_LOW 5'h0F
`define DSIPR_IDX_IVR 5'h10

// command register fields
`define DSIPR_CMD_RX_EN 0
`define DSIPR_CMD_RX_DIS 1
`define DSIPR_CMD_TX_EN 2
`define DSIPR_CMD_TX_DIS 3
`define DSIPR_MISC_RESET_RX 4'h2
`define DSIPR_MISC_RESET_TX 4'h3
`define DSIPR_MISC_RESET_ERR 4'h4
`define DSIPR_MISC_RESET_BRK 4'h5

// channel mode fields
`define DSIPR_MODE_BLOCK_ERR 0
`define DSIPR_MODE_RXINT_FULL 1

// pin 3 / pin 2 routing codes
`define DSIPR_OP3_PORT 2'h0
`define DSIPR_OP3_CT 2'h1
`define DSIPR_OP3_TXB1X 2'h2
`define DSIPR_OP2_PORT 2'h0
`define DSIPR_OP2_TXA16X 2'h1
`define DSIPR_OP2_TXA1X 2'h2

// reset values
`define DSIPR_RST_REG 8'h00
`define DSIPR_RST_GPOUT 8'hFF

`endif

// [hdl/dsipr_pkg.sv]
// types shared by the status/port register bank
package dsipr_pkg;
    typedef logic [7:0] dsipr_byte_t;
    typedef logic [2:0] dsipr_rx_err_t;
    typedef enum logic [1:0] {
        DSIPR_BUS_IDLE = 2'b00,
        DSIPR_BUS_ACK = 2'b01
    } dsipr_bus_state_t;
endpackage

// [hdl/dsipr_regs.sv]
// status, port, interrupt and counter preset register bank of a dual uart, Avalon-MM slave
//
// Behaviour
// - status 7:5 from fifo head in character mode, from error accumulator in block mode, 4:0 live
// - reset-error command clears per-character error flags
// - character mode drops flags on fifo read
// - block mode keeps errors until command/receiver reset
// - writes ignored while transmitter is disabled
// - output pin is complement of port bit
// - config bits 7:4 select port or status
// - config bits 3:2 route pin 3
// - config bits 1:0 route pin 2
// - auxiliary bit 7 selects baud rate set
// - auxiliary bits 3:0 enable input-change interrupt
// - interrupt status byte bit layout
// - mask bit enables matching status bit
// - channel status byte bit layout
// - command 0100 clears break/parity/framing/overrun
// - command 0101 clears break-change status bit
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dsipr_defs.svh"

module dsipr_regs #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [6:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [1:0] i_rx_push,
    input wire dsipr_pkg::dsipr_byte_t i_rx_char_a,
    input wire dsipr_pkg::dsipr_byte_t i_rx_char_b,
    input wire dsipr_pkg::dsipr_rx_err_t i_rx_err_a,
    input wire dsipr_pkg::dsipr_rx_err_t i_rx_err_b,
    input wire logic [1:0] i_tx_taken,
    input wire logic [1:0] i_tx_idle,
    input wire logic [1:0] i_break_change,
    input wire logic i_ct_ready,
    input wire logic i_ct_out,
    input wire logic i_chan_a_transmit_clock_16x,
    input wire logic [1:0] i_transmit_clock_1x,
    input wire logic [1:0] i_receive_clock_1x,
    input wire logic [3:0] i_general_input_pin,
    output logic [1:0] o_rx_enabled,
    output logic [1:0] o_tx_valid,
    output dsipr_pkg::dsipr_byte_t o_tx_data_a,
    output dsipr_pkg::dsipr_byte_t o_tx_data_b,
    output dsipr_pkg::dsipr_byte_t o_general_output_pin,
    output logic o_irq_n,
    output dsipr_pkg::dsipr_byte_t o_interrupt_vector,
    output logic o_baud_rate_set_sel,
    output logic [2:0] o_ct_mode,
    output logic [15:0] o_ct_preset
);
    import dsipr_pkg::*;

    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    typedef struct packed {
        dsipr_bus_state_t bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [1:0][FIFO_DEPTH-1:0][10:0] fifo;
        logic [1:0][PW-1:0] wp;
        logic [1:0][PW-1:0] rp;
        logic [1:0][CW-1:0] cnt;
        logic [1:0][2:0] acc;
        logic [1:0] ovr;
        logic [1:0] rx_en;
        logic [1:0] tx_en;
        logic [1:0] tx_full;
        logic [1:0] brk_chg;
        logic [1:0][7:0] tx_data;
        logic [1:0][1:0] mode;
        logic [7:0] output_pin_function_config;
        logic [7:0] output_port_bits;
        logic [7:0] auxiliary_control;
        logic [7:0] interrupt_enable_mask;
        logic [7:0] ctu;
        logic [7:0] ctl;
        logic [7:0] interrupt_vector;
        logic [2:0][3:0] sync;
        logic [3:0] level;
        logic [3:0] delta;
        logic [7:0] gpout;
        logic irq_n;
    } dsipr_state_t;

    dsipr_state_t s_ff;
    dsipr_state_t nxt_s;

    logic done;
    logic wr;
    logic rd;
    logic [4:0] idx;
    logic [7:0] wd;
    logic [1:0][7:0] stat;
    logic [1:0][10:0] head;
    logic [1:0] rx_rdy;
    logic [1:0] receive_fifo_full;
    logic [1:0] tx_rdy;
    logic [1:0] rx_int;
    logic [7:0] interrupt_status;
    logic [7:0] sel;
    logic [7:0] rmux;
    logic [4:0] base;
    logic [3:0] misc;
    logic [3:0] agree;
    logic [3:0] chg;
    logic [1:0][7:0] rx_char;
    logic [1:0][2:0] rx_err;
    logic push;
    logic pop;
    logic rxrst;

    always_comb begin
        nxt_s = s_ff;
        // index 0 is channel a, index 1 channel b
        rx_char[0] = i_rx_char_a;
        rx_char[1] = i_rx_char_b;
        rx_err[0] = i_rx_err_a;
        rx_err[1] = i_rx_err_b;
        done = (s_ff.bus == DSIPR_BUS_ACK) && (i_avs_read || i_avs_write);
        wr = done && i_avs_write && i_avs_byteenable[0];
        rd = done && i_avs_read;
        idx = i_avs_address[6:2];
        wd = i_avs_writedata[7:0];
        base = 5'h00;
        misc = 4'h0;
        push = 1'b0;
        pop = 1'b0;
        rxrst = 1'b0;

        // live channel status
        for (int ch = 0; ch < 2; ch++) begin
            // head entry only means something while the fifo holds a character
            head[ch] = s_ff.fifo[ch][s_ff.rp[ch]];
            rx_rdy[ch] = (s_ff.cnt[ch] != '0);
            receive_fifo_full[ch] = (s_ff.cnt[ch] == CW'(FIFO_DEPTH));
            tx_rdy[ch] = s_ff.tx_en[ch] && !s_ff.tx_full[ch];
            rx_int[ch] = s_ff.mode[ch][`DSIPR_MODE_RXINT_FULL] ? receive_fifo_full[ch] : rx_rdy[ch];
            stat[ch][4] = s_ff.ovr[ch];
            stat[ch][3] = tx_rdy[ch] && i_tx_idle[ch];
            stat[ch][2] = tx_rdy[ch];
            stat[ch][1] = receive_fifo_full[ch];
            stat[ch][0] = rx_rdy[ch];
            if (s_ff.mode[ch][`DSIPR_MODE_BLOCK_ERR]) begin
                stat[ch][7:5] = s_ff.acc[ch];
            end else begin
                stat[ch][7:5] = rx_rdy[ch] ? head[ch][10:8] : 3'h0;
            end
        end

        interrupt_status[7] = |(s_ff.delta & s_ff.auxiliary_control[3:0]);
        interrupt_status[6] = s_ff.brk_chg[1];
        interrupt_status[5] = rx_int[1];
        interrupt_status[4] = tx_rdy[1];
        interrupt_status[3] = i_ct_ready;
        interrupt_status[2] = s_ff.brk_chg[0];
        interrupt_status[1] = rx_int[0];
        interrupt_status[0] = tx_rdy[0];

        // read multiplexer; write-only registers read as zero
        case (idx)
            `DSIPR_IDX_CHAN_MODE: rmux = {6'h00, s_ff.mode[0]};
            `DSIPR_IDX_CHAN_STATUS: rmux = stat[0];
            `DSIPR_IDX_CHAN_DATA: rmux = head[0][7:0];
            5'(`DSIPR_IDX_CHAN_MODE + `DSIPR_CHAN_STRIDE): rmux = {6'h00, s_ff.mode[1]};
            5'(`DSIPR_IDX_CHAN_STATUS + `DSIPR_CHAN_STRIDE): rmux = stat[1];
            5'(`DSIPR_IDX_CHAN_DATA + `DSIPR_CHAN_STRIDE): rmux = head[1][7:0];
            `DSIPR_IDX_OPR: rmux = s_ff.output_port_bits;
            `DSIPR_IDX_INPUT_CHANGE_STATUS: rmux = {s_ff.delta, s_ff.level};
            `DSIPR_IDX_ISR: rmux = interrupt_status;
            `DSIPR_IDX_COUNTER_PRESET_HIGH: rmux = s_ff.ctu;
            `DSIPR_IDX_COUNTER_PRESET_LOW: rmux = s_ff.ctl;
            `DSIPR_IDX_IVR: rmux = s_ff.interrupt_vector;
            default: rmux = 8'h00;
        endcase

        // one wait cycle: request seen, answer stands in the next cycle
        case (s_ff.bus)
            // read data captured at acceptance; the pop lands at completion
            DSIPR_BUS_IDLE: begin
                if (i_avs_read || i_avs_write) begin
                    nxt_s.bus = DSIPR_BUS_ACK;
                    nxt_s.waitreq = 1'b0;
                    nxt_s.rdata = {24'h000000, i_avs_read ? rmux : 8'h00};
                end
            end
            DSIPR_BUS_ACK: begin
                nxt_s.bus = DSIPR_BUS_IDLE;
                nxt_s.waitreq = 1'b1;
            end
            default: begin
                nxt_s.bus = DSIPR_BUS_IDLE;
                nxt_s.waitreq = 1'b1;
            end
        endcase

        // shared registers
        if (wr) begin
            case (idx)
                `DSIPR_IDX_OUTPUT_PIN_FUNCTION_CONFIG: nxt_s.output_pin_function_config = wd;
                `DSIPR_IDX_OPR: nxt_s.output_port_bits = wd;
                `DSIPR_IDX_ACR: nxt_s.auxiliary_control = wd;
                `DSIPR_IDX_IMR: nxt_s.interrupt_enable_mask = wd;
                `DSIPR_IDX_COUNTER_PRESET_HIGH: nxt_s.ctu = wd;
                `DSIPR_IDX_COUNTER_PRESET_LOW: nxt_s.ctl = wd;
                `DSIPR_IDX_IVR: nxt_s.interrupt_vector = wd;
                default: nxt_s.output_port_bits = s_ff.output_port_bits;
            endcase
        end

        for (int ch = 0; ch < 2; ch++) begin
            base = 5'(`DSIPR_CHAN_STRIDE * ch);
            misc = 4'h0;
            rxrst = 1'b0;
            if (wr && idx == 5'(base + `DSIPR_IDX_CHAN_MODE)) begin
                nxt_s.mode[ch] = wd[1:0];
            end
            if (wr && idx == 5'(base + `DSIPR_IDX_CHAN_CMD)) begin
                misc = wd[7:4];
                if (wd[`DSIPR_CMD_RX_EN]) begin
                    nxt_s.rx_en[ch] = 1'b1;
                end
                if (wd[`DSIPR_CMD_RX_DIS]) begin
                    nxt_s.rx_en[ch] = 1'b0;
                end
                if (wd[`DSIPR_CMD_TX_EN]) begin
                    nxt_s.tx_en[ch] = 1'b1;
                end
                if (wd[`DSIPR_CMD_TX_DIS]) begin
                    nxt_s.tx_en[ch] = 1'b0;
                end
            end
            // clears first, so that a same-cycle event below still sets its flag
            case (misc)
                `DSIPR_MISC_RESET_RX: begin
                    rxrst = 1'b1;
                    nxt_s.rx_en[ch] = 1'b0;
                    nxt_s.acc[ch] = 3'h0;
                    nxt_s.ovr[ch] = 1'b0;
                end
                `DSIPR_MISC_RESET_TX: begin
                    nxt_s.tx_en[ch] = 1'b0;
                    nxt_s.tx_full[ch] = 1'b0;
                end
                `DSIPR_MISC_RESET_ERR: begin
                    nxt_s.acc[ch] = 3'h0;
                    nxt_s.ovr[ch] = 1'b0;
                    for (int e = 0; e < FIFO_DEPTH; e++) begin
                        nxt_s.fifo[ch][e][10:8] = 3'h0;
                    end
                end
                `DSIPR_MISC_RESET_BRK: nxt_s.brk_chg[ch] = 1'b0;
                default: nxt_s.brk_chg[ch] = nxt_s.brk_chg[ch];
            endcase
            if (i_break_change[ch]) begin
                nxt_s.brk_chg[ch] = 1'b1;
            end

            // transmit holding register
            if (i_tx_taken[ch]) begin
                nxt_s.tx_full[ch] = 1'b0;
            end
            if (wr && idx == 5'(base + `DSIPR_IDX_CHAN_DATA) && tx_rdy[ch]) begin
                nxt_s.tx_data[ch] = wd;
                nxt_s.tx_full[ch] = 1'b1;
            end

            // receive fifo, errors travel with each character
            pop = rd && idx == 5'(base + `DSIPR_IDX_CHAN_DATA) && rx_rdy[ch];
            push = i_rx_push[ch] && s_ff.rx_en[ch] && !receive_fifo_full[ch] && !rxrst;
            if (i_rx_push[ch] && s_ff.rx_en[ch] && receive_fifo_full[ch] && !rxrst) begin
                nxt_s.ovr[ch] = 1'b1;
            end
            if (push) begin
                nxt_s.fifo[ch][s_ff.wp[ch]] = {rx_err[ch], rx_char[ch]};
                nxt_s.wp[ch] = PW'(s_ff.wp[ch] + 1'b1);
                nxt_s.acc[ch] = nxt_s.acc[ch] | rx_err[ch];
            end
            if (pop) begin
                nxt_s.rp[ch] = PW'(s_ff.rp[ch] + 1'b1);
            end
            if (push && !pop) begin
                nxt_s.cnt[ch] = CW'(s_ff.cnt[ch] + 1'b1);
            end else if (pop && !push) begin
                nxt_s.cnt[ch] = CW'(s_ff.cnt[ch] - 1'b1);
            end
            // receiver reset flushes, and the flush outranks a pending read
            if (rxrst) begin
                nxt_s.wp[ch] = '0;
                nxt_s.rp[ch] = '0;
                nxt_s.cnt[ch] = '0;
            end
        end

        // input change detect: a level counts once the second and third stages agree
        nxt_s.sync = {s_ff.sync[1], s_ff.sync[0], i_general_input_pin};
        agree = ~(s_ff.sync[1] ^ s_ff.sync[2]);
        chg = agree & (s_ff.sync[2] ^ s_ff.level);
        nxt_s.level = (agree & s_ff.sync[2]) | (~agree & s_ff.level);
        if (rd && idx == `DSIPR_IDX_INPUT_CHANGE_STATUS) begin
            nxt_s.delta = 4'h0;
        end
        nxt_s.delta = nxt_s.delta | chg;

        // output pin selection
        sel[7] = s_ff.output_pin_function_config[7] ? tx_rdy[1] : s_ff.output_port_bits[7];
        sel[6] = s_ff.output_pin_function_config[6] ? tx_rdy[0] : s_ff.output_port_bits[6];
        sel[5] = s_ff.output_pin_function_config[5] ? rx_int[1] : s_ff.output_port_bits[5];
        sel[4] = s_ff.output_pin_function_config[4] ? rx_int[0] : s_ff.output_port_bits[4];
        case (s_ff.output_pin_function_config[3:2])
            `DSIPR_OP3_PORT: sel[3] = s_ff.output_port_bits[3];
            `DSIPR_OP3_CT: sel[3] = i_ct_out;
            `DSIPR_OP3_TXB1X: sel[3] = i_transmit_clock_1x[1];
            default: sel[3] = i_receive_clock_1x[1];
        endcase
        case (s_ff.output_pin_function_config[1:0])
            `DSIPR_OP2_PORT: sel[2] = s_ff.output_port_bits[2];
            `DSIPR_OP2_TXA16X: sel[2] = i_chan_a_transmit_clock_16x;
            `DSIPR_OP2_TXA1X: sel[2] = i_transmit_clock_1x[0];
            default: sel[2] = i_receive_clock_1x[0];
        endcase
        sel[1] = s_ff.output_port_bits[1];
        sel[0] = s_ff.output_port_bits[0];
        // registered pins, so a routed clock shows up one cycle late
        nxt_s.gpout = ~sel;

        // level interrupt, low for as long as an enabled source holds
        nxt_s.irq_n = ~|(interrupt_status & s_ff.interrupt_enable_mask);

        // reset last, so it outranks every update above
        if (i_rst) begin
            nxt_s = '0;
            nxt_s.bus = DSIPR_BUS_IDLE;
            nxt_s.waitreq = 1'b1;
            nxt_s.irq_n = 1'b1;
            nxt_s.gpout = `DSIPR_RST_GPOUT;
            nxt_s.output_port_bits = `DSIPR_RST_REG;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        s_ff <= nxt_s;
    end

    // every output is a field of the state register
    assign o_avs_readdata = s_ff.rdata;
    assign o_avs_waitrequest = s_ff.waitreq;
    assign o_rx_enabled = s_ff.rx_en;
    assign o_tx_valid = s_ff.tx_full;
    assign o_tx_data_a = s_ff.tx_data[0];
    assign o_tx_data_b = s_ff.tx_data[1];
    assign o_general_output_pin = s_ff.gpout;
    assign o_irq_n = s_ff.irq_n;
    assign o_interrupt_vector = s_ff.interrupt_vector;
    assign o_baud_rate_set_sel = s_ff.auxiliary_control[7];
    assign o_ct_mode = s_ff.auxiliary_control[6:4];
    assign o_ct_preset = {s_ff.ctu, s_ff.ctl};
endmodule
